// ### dv/analog_front_model.sv
`timescale 1ns/10ps
// ----------
// Comparator stand-in
// ----------
module analog_front_model (
    input wire logic [7:0] channelRoute,
    input wire logic [7:0] ladderCode,
    input wire logic [63:0] levels,
    output logic compareHigh
);
    logic [7:0] picked;
    // Unselected route gives zero, so a bad route shows as a wrong code
    always_comb begin
        picked = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (channelRoute[i]) picked = levels[i*8 +: 8];
        end
        compareHigh = (picked >= ladderCode);
    end
endmodule : analog_front_model

// ### dv/sar_adc_mux_control_tb_top.sv
`timescale 1ns/10ps
// ----------
// Bench
// ----------
module sar_adc_mux_control_tb_top;
    import sar_ctrl_pkg::*;
    logic clock = 0, rst = 1, addressLatch = 0, conversion_trigger = 0, outputEnable = 0;
    logic [2:0] channelSelect = 3'h0;
    logic compareHigh, conversionDone;
    logic [7:0] channelRoute, ladderCode, dataOut, dataOutEnable;
    logic [63:0] levels = 64'h00ffc45a807f01a5;
    int num_errors = 0, n_tests = 0;
    always #5 clock = ~clock;
    sar_adc_mux_control dut_u (.clock(clock), .rst(rst), .channelSelect(channelSelect),
        .addressLatch(addressLatch), .conversion_trigger(conversion_trigger),
        .outputEnable(outputEnable), .compareHigh(compareHigh), .channelRoute(channelRoute),
        .ladderCode(ladderCode), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
        .conversionDone(conversionDone));
    analog_front_model front_u (.channelRoute(channelRoute), .ladderCode(ladderCode),
        .levels(levels), .compareHigh(compareHigh));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic choose(input int ch);
        @(negedge clock) channelSelect = 3'(ch);
        @(negedge clock) addressLatch = 1;
        repeat (MIN_PULSE_CYCLES) @(negedge clock);
        addressLatch = 0;
        channelSelect = ~3'(ch);
        repeat (2) @(negedge clock);
        check("route", channelRoute, 8'h01 << ch);
    endtask : choose
    task automatic convert(input logic [7:0] want);
        int n;
        logic [7:0] prev;
        @(negedge clock) conversion_trigger = 1;
        for (n = 0; n < 9 && conversionDone !== 1'b0; n++) @(negedge clock);
        check("done fall", 8'(n <= DONE_FALL_MAX_CYCLES), 8'h01);
        repeat (MIN_PULSE_CYCLES - n) @(negedge clock);
        conversion_trigger = 0;
        prev = dataOut;
        for (n = 0; n < 40 && conversionDone !== 1'b1; n++) begin
            prev = dataOut;
            @(negedge clock);
        end
        if (n == 40) begin
            num_errors++;
            close_out();
        end
        check("early result", prev, want);
        check("result", dataOut, want);
    endtask : convert
    task automatic abort_run(input logic [7:0] want, input logic [7:0] old);
        @(negedge clock) conversion_trigger = 1;
        repeat (MIN_PULSE_CYCLES) @(negedge clock);
        conversion_trigger = 0;
        repeat (4) @(negedge clock);
        check("aborted done", 8'(conversionDone), 8'h00);
        check("held result", dataOut, old);
        convert(want);
    endtask : abort_run
    task automatic free_run(input logic [7:0] want);
        convert(want);
        for (int k = 0; k < 60; k++) @(negedge clock) conversion_trigger = conversionDone;
        @(negedge clock) conversion_trigger = 0;
        repeat (20) @(negedge clock);
        check("free run result", dataOut, want);
        check("free run done", 8'(conversionDone), 8'h01);
    endtask : free_run
    task automatic drive_check;
        @(negedge clock) outputEnable = 1;
        @(negedge clock) check("drive on", dataOutEnable, 8'hff);
        outputEnable = 0;
        @(negedge clock) check("drive off", dataOutEnable, 8'h00);
    endtask : drive_check
    initial begin
        repeat (6) @(negedge clock);
        rst = 0;
        check("idle done", 8'(conversionDone), 8'h01);
        check("reset data", dataOut, 8'h00);
        for (int ch = 7; ch >= 0; ch--) choose(ch);
        foreach (levels[i]) begin
            if (i % 8 == 0 && i < 40) begin
                choose(i / 8);
                convert(levels[i +: 8]);
            end
        end
        choose(6);
        abort_run(8'hff, dataOut);
        choose(5);
        free_run(8'hc4);
        drive_check();
        close_out();
    end
endmodule : sar_adc_mux_control_tb_top

// ### include/sar_ctrl_pkg.sv
// Functional notes
// [R1] Channel select is captured on the strobe's rising edge and held until the next.
// [R2] Captured select C,B,A picks analog input 0..7, A least significant.
// [R3] Trigger rising edge clears the approximation register.
// [R4] Approximation starts on the trigger's falling edge.
// [R5] A new trigger during conversion aborts it; no result is delivered.
// [R6] Done may feed the trigger; one external pulse needed after power-up. Code needs none: done resets high and trigPrev low.
// [R7] Done falls within 0 to 8 clock periods after the trigger rises.
// [R8] Result register loads one clock before done rises.
// [R9] Exactly 8 iterations, most significant bit first, give an 8-bit code.
// [R10] Result is positive true: high means one, bigger input bigger code.
// [R11] Output enable drives the result; otherwise data outputs float. Code always drives dataOut and only drops dataOutEnable, one clock late.
// [R12] Other party holds trigger and strobe high at least 200 ns.
// [R13] Done stays high when idle; result held until the next completion.
package sar_ctrl_pkg;
    localparam int RESULT_WIDTH = 8;
    localparam int SELECT_WIDTH = 3;
    localparam int CHANNEL_COUNT = 8;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int MIN_PULSE_NS = 200;
    localparam int MIN_PULSE_CYCLES = (MIN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DONE_FALL_MAX_CYCLES = 8;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 8'h00;
    localparam logic [SELECT_WIDTH-1:0] SELECT_RESET = 3'h0;

    typedef enum logic [1:0] {
        IDLE_STATE = 2'b00,
        ARMED_STATE = 2'b01,
        CONVERT_STATE = 2'b10,
        LOAD_STATE = 2'b11
    } phase_type;
endpackage : sar_ctrl_pkg

// ### verilog/bit_trial.sv
`timescale 1ns/10ps
// Forms the trial code for one iteration: keeps decided bits, sets the bit under test.
module bit_trial
    import sar_ctrl_pkg::*;
#(
    parameter int WIDTH = RESULT_WIDTH
) (
    input wire logic [WIDTH-1:0] approx,
    input wire logic [WIDTH-1:0] testMask,
    output logic [WIDTH-1:0] trial
);
    always_comb begin
        trial = approx | testMask;
    end
endmodule : bit_trial

// ### verilog/sar_adc_mux_control.sv
`timescale 1ns/10ps
module sar_adc_mux_control
    import sar_ctrl_pkg::*;
#(
    parameter int WIDTH = RESULT_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [SELECT_WIDTH-1:0] channelSelect,
    input wire logic addressLatch,
    input wire logic conversion_trigger,
    input wire logic outputEnable,
    input wire logic compareHigh,
    output logic [CHANNEL_COUNT-1:0] channelRoute,
    output logic [WIDTH-1:0] ladderCode,
    output logic [WIDTH-1:0] dataOut,
    output logic [WIDTH-1:0] dataOutEnable,
    output logic conversionDone
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phase_type phase;
        logic latchPrev;
        logic trigPrev;
        logic [SELECT_WIDTH-1:0] select;
        logic [CHANNEL_COUNT-1:0] route;
        logic [WIDTH-1:0] approximation_register;
        logic [WIDTH-1:0] testMask;
        logic [WIDTH-1:0] trialOut;
        logic [WIDTH-1:0] result;
        logic [WIDTH-1:0] drive;
        logic done;
    } state_type;

    state_type cur;
    state_type next_cur;
    logic [WIDTH-1:0] trial;
    logic [WIDTH-1:0] stepApprox;
    logic [WIDTH-1:0] stepMask;

    function automatic logic [CHANNEL_COUNT-1:0] decode(input logic [SELECT_WIDTH-1:0] sel);
        decode = {{(CHANNEL_COUNT-1){1'b0}}, 1'b1} << sel;
    endfunction : decode

    // ------------------------------------------------------------
    // One iteration step
    // ------------------------------------------------------------
    // Next trial must be built from the updated bits, else the ladder lags a step
    always_comb begin
        stepApprox = cur.approximation_register;
        if (compareHigh) begin
            stepApprox = cur.approximation_register | cur.testMask; // [R10]
        end
        stepMask = cur.testMask >> 1; // [R9]
    end

    bit_trial #(.WIDTH(WIDTH)) trialUnit (
        .approx(stepApprox),
        .testMask(stepMask),
        .trial(trial)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.latchPrev = addressLatch;
        next_cur.trigPrev = conversion_trigger;
        if (addressLatch && !cur.latchPrev) begin
            next_cur.select = channelSelect; // [R1]
            next_cur.route = decode(channelSelect); // [R2]
        end
        if (conversion_trigger && !cur.trigPrev) begin
            // Rising edge wins over anything in flight; done fed back restarts too
            next_cur.approximation_register = '0; // [R3]
            next_cur.testMask = '0; // [R6]
            next_cur.trialOut = '0;
            next_cur.done = 1'b0; // [R7]
            next_cur.phase = ARMED_STATE; // [R5]
        end else begin
            unique case (cur.phase)
                IDLE_STATE: begin
                    next_cur.done = 1'b1; // [R13]
                end
                ARMED_STATE: begin
                    if (!conversion_trigger) begin
                        next_cur.phase = CONVERT_STATE; // [R4]
                        next_cur.testMask = {1'b1, {(WIDTH-1){1'b0}}}; // [R9]
                        next_cur.trialOut = {1'b1, {(WIDTH-1){1'b0}}};
                    end
                end
                CONVERT_STATE: begin
                    // Comparator answers for the trial code presented this cycle
                    next_cur.approximation_register = stepApprox; // [R10]
                    next_cur.testMask = stepMask; // [R9]
                    next_cur.trialOut = trial;
                    if (cur.testMask[0]) begin
                        next_cur.phase = LOAD_STATE;
                    end
                end
                LOAD_STATE: begin
                    next_cur.result = cur.approximation_register; // [R8]
                    next_cur.phase = IDLE_STATE;
                end
            endcase
        end
        next_cur.drive = outputEnable ? {WIDTH{1'b1}} : '0; // [R11]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur <= '{phase: IDLE_STATE, latchPrev: 1'b0, trigPrev: 1'b0,
                     select: SELECT_RESET, route: {{(CHANNEL_COUNT-1){1'b0}}, 1'b1},
                     approximation_register: RESULT_RESET, testMask: RESULT_RESET,
                     trialOut: RESULT_RESET, result: RESULT_RESET,
                     drive: RESULT_RESET, done: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // dataOut is always driven; dataOutEnable goes low when disabled so the pad can float the pins
    assign channelRoute = cur.route;
    assign ladderCode = cur.trialOut;
    assign dataOut = cur.result; // [R13]
    assign dataOutEnable = cur.drive;
    assign conversionDone = cur.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    done_falls_a: assert property (@(posedge clock) disable iff (rst) // [R7]
        $rose(conversion_trigger) |-> ##[1:8] !conversionDone)
        else $error("done did not fall after trigger");
    clear_on_rise_a: assert property (@(posedge clock) disable iff (rst) // [R3]
        $rose(conversion_trigger) |=> cur.approximation_register == '0)
        else $error("approximation not cleared");
    wait_fall_a: assert property (@(posedge clock) disable iff (rst) // [R4]
        (cur.phase == ARMED_STATE && conversion_trigger) |=> cur.phase != CONVERT_STATE)
        else $error("conversion began while trigger high");
    result_before_done_a: assert property (@(posedge clock) disable iff (rst) // [R8]
        $rose(conversionDone) |-> $past(cur.phase, 2) == LOAD_STATE)
        else $error("result not loaded before done");
    eight_iter_a: assert property (@(posedge clock) disable iff (rst || conversion_trigger) // [R9]
        (cur.phase == CONVERT_STATE && cur.testMask[WIDTH-1] && !$rose(conversion_trigger))
        |=> (cur.phase == CONVERT_STATE)[*7])
        else $error("iteration count wrong");
    abort_no_result_a: assert property (@(posedge clock) disable iff (rst) // [R5]
        ($rose(conversion_trigger) && cur.phase == CONVERT_STATE) |=> $stable(dataOut))
        else $error("aborted conversion delivered result");
    latch_sel_a: assert property (@(posedge clock) disable iff (rst) // [R1]
        $rose(addressLatch) |=> channelRoute == decode($past(channelSelect)))
        else $error("channel not captured");
    hold_sel_a: assert property (@(posedge clock) disable iff (rst) // [R1]
        !$rose(addressLatch) |=> $stable(channelRoute))
        else $error("channel changed without strobe");
    drive_a: assert property (@(posedge clock) disable iff (rst) // [R11]
        outputEnable |=> dataOutEnable == {WIDTH{1'b1}})
        else $error("data not driven");
    float_a: assert property (@(posedge clock) disable iff (rst) // [R11]
        !outputEnable |=> dataOutEnable == '0)
        else $error("data driven while disabled");
    idle_done_a: assert property (@(posedge clock) disable iff (rst) // [R13]
        (cur.phase == IDLE_STATE && !$rose(conversion_trigger)) |=> conversionDone)
        else $error("done low while idle");
    conv_c: cover property (@(posedge clock) disable iff (rst) $rose(conversionDone));
    abort_c: cover property (@(posedge clock) disable iff (rst)
        cur.phase == CONVERT_STATE && $rose(conversion_trigger));
    latch_c: cover property (@(posedge clock) disable iff (rst) $rose(addressLatch));
endmodule : sar_adc_mux_control
